// ===== include/pgm_consts.svh
// Purpose: constants for the pin function / general-purpose i/o mux
// Assumes: one 20 MHz clock, asynchronous active-low reset
// Notes: reset values and pin counts live here
`ifndef PGM_CONSTS_SVH
`define PGM_CONSTS_SVH
`define PGM_NPINS 16
`define PGM_SEL_RST 16'h0000
`define PGM_DOUT_RST 16'h0000
`define PGM_DBG_NPINS 4
`define PGM_DBG_ZERO 4'h0
`endif

// ===== include/pgm_pkg.sv
// Purpose: types for the pin mux
// Assumes: pgm_consts.svh
// Notes: pin groups carried as packed structs
`default_nettype none
`include "pgm_consts.svh"
package pgm_pkg;
  typedef struct packed {
    logic [`PGM_NPINS-1:0] dout;
    logic [`PGM_NPINS-1:0] oe;
  } pgm_pin_drive_t;
  typedef struct packed {
    logic [`PGM_DBG_NPINS-1:0] dout;
    logic [`PGM_DBG_NPINS-1:0] oe;
  } pgm_dbg_drive_t;
  typedef enum logic [1:0] {
    PGM_MODE_OFF = 2'b00,
    PGM_MODE_SCAN = 2'b01,
    PGM_MODE_DEBUG = 2'b10
  } pgm_mode_t;
endpackage
`default_nettype wire

// ===== verification/pgm_board.sv
// Purpose: board devices on the muxed pins
// Assumes: design drive wins where its enable is high
// Notes: released pins show a fixed board pattern
`default_nettype none
module pgm_board import pgm_pkg::*; (
  // design drive
  input wire pgm_pin_drive_t i_drive,
  // board side
  output logic [15:0] o_pin,
  output logic [3:0] o_test_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_pin = (i_drive.oe & i_drive.dout) | (~i_drive.oe & 16'h3c3c);
  assign o_test_mode = 4'h0;
endmodule // pgm_board
`default_nettype wire

// ===== verification/pgm_mux_properties.sv
// Purpose: port checks for the pin mux
// Assumes: outputs registered one edge after their inputs, two edges after the config write and after i_dbg_active
// Notes: bound to every pgm_mux instance
`default_nettype none
module pgm_mux_properties import pgm_pkg::*; #(parameter int N = 16) (
  input wire logic i_ref_clk, i_arst_n, i_cfg_we, i_three_state_all_request, i_dbg_active,
  input wire logic [N-1:0] i_pin, o_gpio_din, i_cfg_sel_gpio, i_cfg_gpio_dout, i_per_dout,
  input wire pgm_pin_drive_t o_pin,
  input wire pgm_dbg_drive_t o_debug_capture_pins, o_core_status_pins,
  input wire pgm_mode_t i_mode,
  input wire logic i_scan_reset_debug_clock_pin, i_scan_mode_breakpoint_pin,
  input wire logic o_scan_reset_n, o_debug_serial_clock, o_scan_mode_select, o_breakpoint_request
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_write; i_cfg_we ##1 !i_cfg_we; endsequence
  // past reset guard: the first edge after release still holds reset values
  a_gpio_in_follows: assert property ($past(i_arst_n) |-> o_gpio_din == $past(i_pin))
    else $error("gpio input does not follow pin");
  a_select_picks_drive: assert property (s_write |=> o_pin.dout == (($past(i_cfg_sel_gpio, 2)
    & $past(i_cfg_gpio_dout, 2)) | (~$past(i_cfg_sel_gpio, 2) & $past(i_per_dout))))
    else $error("pin drive ignores select");
  a_release_all_pins: assert property ($past(i_three_state_all_request) |-> o_pin.oe == 0
    && o_debug_capture_pins.oe == 0 && o_core_status_pins.oe == 0) else $error("pins driven while released");
  a_capture_quiet: assert property (o_debug_capture_pins.oe != 0 |-> $past(i_dbg_active, 2))
    else $error("capture pins driven while idle");
  a_status_quiet: assert property (o_core_status_pins.oe != 0 |-> $past(i_dbg_active, 2))
    else $error("status pins driven while idle");
  a_scan_reset_use: assert property ($past(i_arst_n) |-> o_scan_reset_n ==
    ($past(i_mode) != PGM_MODE_SCAN || $past(i_scan_reset_debug_clock_pin))) else $error("scan reset wrong");
  a_debug_clock_use: assert property ($past(i_arst_n) |-> o_debug_serial_clock ==
    ($past(i_mode) == PGM_MODE_DEBUG && $past(i_scan_reset_debug_clock_pin))) else $error("debug clock wrong");
  a_scan_select_use: assert property ($past(i_arst_n) |-> o_scan_mode_select ==
    ($past(i_mode) == PGM_MODE_SCAN && $past(i_scan_mode_breakpoint_pin))) else $error("mode select wrong");
  a_breakpoint_use: assert property ($past(i_arst_n) |-> o_breakpoint_request ==
    ($past(i_mode) == PGM_MODE_DEBUG && $past(i_scan_mode_breakpoint_pin))) else $error("breakpoint wrong");
endmodule // pgm_mux_properties
bind pgm_mux pgm_mux_properties #(.N(N)) chk_i (.*);
`default_nettype wire

// ===== verification/pgm_mux_test.sv
// Purpose: self-checking bench for the pin mux
// Assumes: 50 ns clock, inputs 5 ns after the edge
// Notes: debug pins loop their own drive back
`default_nettype none
module pgm_mux_test import pgm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, we, three_state_all_request, dact, p, rn, dclk, ssel, bkpt;
  logic [15:0] sel, gd, pd, pin, din, pdin;
  logic [3:0] cgd, sgd;
  pgm_pin_drive_t drv;
  pgm_dbg_drive_t dcap, dst;
  pgm_mode_t mode;
  int fails = 0, total_checks = 0;
  logic [63:0] rows [4] = '{64'h0000_ffff_1234_1234, 64'hffff_a5a5_0000_a5a5,
    64'h00ff_0f0f_f0f0_f00f, 64'h8001_8000_7ffe_fffe};
  always #25 clk = ~clk;
  pgm_board brd (.i_drive(drv), .o_pin(pin), .o_test_mode());
  pgm_mux uut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_cfg_we(we), .i_cfg_sel_gpio(sel), .i_cfg_gpio_dout(gd),
    .i_cfg_gpio_oe(16'hffff), .o_gpio_din(din), .i_per_dout(pd), .i_per_oe(16'hffff), .o_per_din(pdin),
    .i_pin(pin), .o_pin(drv), .i_three_state_all_request(three_state_all_request), .i_dbg_active(dact),
    .i_debug_capture_data(4'ha), .i_core_status_data(4'h5), .i_debug_capture_pins(dcap.dout),
    .i_core_status_pins(dst.dout), .o_debug_capture_pins(dcap), .o_core_status_pins(dst),
    .o_debug_capture_gpio_din(cgd), .o_core_status_gpio_din(sgd), .i_mode(mode),
    .i_scan_reset_debug_clock_pin(p), .i_scan_mode_breakpoint_pin(p), .o_scan_reset_n(rn),
    .o_debug_serial_clock(dclk), .o_scan_mode_select(ssel), .o_breakpoint_request(bkpt));
  task tick;
    @(posedge clk);
    #5;
  endtask
  task chk(input string n, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task finish_test;
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {clk, rst_n, we, three_state_all_request, dact, p} = 6'b000010;
    {sel, gd, pd} = {16'h0000, 16'h0000, 16'h1234};
    mode = PGM_MODE_OFF;
    repeat (5) tick;
    chk("debug oe in reset", {dcap.oe, dst.oe}, 16'h0000);
    rst_n = 1;
    tick;
    tick;
    chk("reset function", drv.dout, 16'h1234);
    foreach (rows[i]) begin
      {sel, gd, pd} = rows[i][63:16];
      we = 1;
      tick;
      we = 0;
      tick;
      chk("pin drive", drv.dout, rows[i][15:0]);
      chk("pin enable", drv.oe, 16'hffff);
      tick;
      chk("gpio input", din, pin);
      chk("peripheral input", pdin, pin);
    end
    // mid-run reset must drop the gpio selections again
    rst_n = 0;
    #1;
    chk("pins in reset", drv.oe, 16'h0000);
    tick;
    rst_n = 1;
    tick;
    tick;
    chk("reset function again", drv.dout, 16'h7ffe);
    three_state_all_request = 1;
    tick;
    chk("released oe", drv.oe, 16'h0000);
    chk("released debug oe", {dcap.oe, dst.oe}, 16'h0000);
    tick;
    chk("gpio input released", din, 16'h3c3c);
    three_state_all_request = 0;
    tick;
    tick;
    chk("debug drive", {dcap, dst}, 16'haf5f);
    chk("debug pin inputs", {cgd, sgd}, 16'h00a5);
    for (int m = 0; m < 6; m++) begin
      mode = pgm_mode_t'(m / 2);
      p = m[0];
      tick;
      chk("shared pins", {rn, dclk, ssel, bkpt}, {m/2 != 1 || p, m/2 == 2 && p, m/2 == 1 && p, m/2 == 2 && p});
    end
    finish_test;
  end
endmodule // pgm_mux_test
`default_nettype wire

// ===== verilog/pgm_mux.sv
// Purpose: pin function mux with general-purpose i/o, debug pin defaults
// Assumes: one clock i_ref_clk at 20 MHz, i_arst_n async active low
// Notes: no software bus; select and data arrive as plain inputs
`default_nettype none
`include "pgm_consts.svh"
module pgm_mux #(
  parameter int N = `PGM_NPINS
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // software-side control (register contents, written by a write strobe)
  input wire logic i_cfg_we,
  input wire logic [N-1:0] i_cfg_sel_gpio,
  input wire logic [N-1:0] i_cfg_gpio_dout,
  input wire logic [N-1:0] i_cfg_gpio_oe,
  output logic [N-1:0] o_gpio_din,
  // peripheral side
  input wire logic [N-1:0] i_per_dout,
  input wire logic [N-1:0] i_per_oe,
  output logic [N-1:0] o_per_din,
  // general pins
  input wire logic [N-1:0] i_pin,
  output pgm_pkg::pgm_pin_drive_t o_pin,
  // global three-state request
  input wire logic i_three_state_all_request,
  // debug and status pins
  input wire logic i_dbg_active,
  input wire logic [`PGM_DBG_NPINS-1:0] i_debug_capture_data,
  input wire logic [`PGM_DBG_NPINS-1:0] i_core_status_data,
  input wire logic [`PGM_DBG_NPINS-1:0] i_debug_capture_pins,
  input wire logic [`PGM_DBG_NPINS-1:0] i_core_status_pins,
  output pgm_pkg::pgm_dbg_drive_t o_debug_capture_pins,
  output pgm_pkg::pgm_dbg_drive_t o_core_status_pins,
  output logic [`PGM_DBG_NPINS-1:0] o_debug_capture_gpio_din,
  output logic [`PGM_DBG_NPINS-1:0] o_core_status_gpio_din,
  // shared scan/debug pins
  input wire pgm_pkg::pgm_mode_t i_mode,
  input wire logic i_scan_reset_debug_clock_pin,
  input wire logic i_scan_mode_breakpoint_pin,
  output logic o_scan_reset_n,
  output logic o_debug_serial_clock,
  output logic o_scan_mode_select,
  output logic o_breakpoint_request
);
  import pgm_pkg::*;

  // ---------------------------------------------
  // control state
  // ---------------------------------------------
  logic [N-1:0] sel_gpio;
  logic [N-1:0] gpio_dout;
  logic [N-1:0] gpio_oe;
  logic dbg_live;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sel_gpio <= `PGM_SEL_RST;
      gpio_dout <= `PGM_DOUT_RST;
      gpio_oe <= `PGM_SEL_RST;
    end else if (i_cfg_we) begin
      sel_gpio <= i_cfg_sel_gpio;
      gpio_dout <= i_cfg_gpio_dout;
      gpio_oe <= i_cfg_gpio_oe;
    end
  end

  // debug pins stay released until i_dbg_active is sampled high, and again whenever it is sampled low
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dbg_live <= 1'b0;
    end else begin
      dbg_live <= i_dbg_active;
    end
  end

  // ---------------------------------------------
  // pin mux
  // ---------------------------------------------
  wire logic [N-1:0] next_dout;
  wire logic [N-1:0] next_oe;
  pgm_pin_cell #(.N(N)) u_cell (
    .i_sel_gpio(sel_gpio),
    .i_gpio_dout(gpio_dout),
    .i_three_state_all_request(i_three_state_all_request),
    .i_per_dout(i_per_dout),
    .i_per_oe(i_per_oe),
    .i_gpio_oe(gpio_oe),
    .o_dout(next_dout),
    .o_oe(next_oe)
  );

  wire logic dbg_drive;
  assign dbg_drive = dbg_live & ~i_three_state_all_request;
  wire logic is_scan;
  wire logic is_debug;
  assign is_scan = (i_mode == PGM_MODE_SCAN);
  assign is_debug = (i_mode == PGM_MODE_DEBUG);

  // ---------------------------------------------
  // registered outputs
  // ---------------------------------------------
  // registering costs one cycle of latency on every pin but keeps outputs glitch free
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin <= '0;
      o_gpio_din <= '0;
      o_per_din <= '0;
      o_debug_capture_pins <= '0;
      o_core_status_pins <= '0;
      o_debug_capture_gpio_din <= `PGM_DBG_ZERO;
      o_core_status_gpio_din <= `PGM_DBG_ZERO;
      o_scan_reset_n <= 1'b0;
      o_debug_serial_clock <= 1'b0;
      o_scan_mode_select <= 1'b0;
      o_breakpoint_request <= 1'b0;
    end else begin
      o_pin.dout <= next_dout;
      o_pin.oe <= next_oe;
      o_gpio_din <= i_pin;
      o_per_din <= i_pin;
      o_debug_capture_pins.dout <= i_debug_capture_data;
      o_debug_capture_pins.oe <= {`PGM_DBG_NPINS{dbg_drive}};
      o_core_status_pins.dout <= i_core_status_data;
      o_core_status_pins.oe <= {`PGM_DBG_NPINS{dbg_drive}};
      o_debug_capture_gpio_din <= i_debug_capture_pins;
      o_core_status_gpio_din <= i_core_status_pins;
      o_scan_reset_n <= is_scan ? i_scan_reset_debug_clock_pin : 1'b1;
      o_debug_serial_clock <= is_debug & i_scan_reset_debug_clock_pin;
      o_scan_mode_select <= is_scan & i_scan_mode_breakpoint_pin;
      o_breakpoint_request <= is_debug & i_scan_mode_breakpoint_pin;
    end
  end
endmodule // pgm_mux
`default_nettype wire

// ===== verilog/pgm_pin_cell.sv
// Purpose: one bank of muxed pins: select and drive
// Assumes: pins synchronous to the clock
// Notes: combinational, outputs registered by the top
`default_nettype none
`include "pgm_consts.svh"
module pgm_pin_cell #(
  parameter int N = `PGM_NPINS
) (
  // controls
  input wire logic [N-1:0] i_sel_gpio,
  input wire logic [N-1:0] i_gpio_dout,
  input wire logic i_three_state_all_request,
  // peripheral side
  input wire logic [N-1:0] i_per_dout,
  input wire logic [N-1:0] i_per_oe,
  // gpio direction
  input wire logic [N-1:0] i_gpio_oe,
  // result
  output logic [N-1:0] o_dout,
  output logic [N-1:0] o_oe
);
  wire logic [N-1:0] mux_dout;
  wire logic [N-1:0] mux_oe;
  assign mux_dout = (i_sel_gpio & i_gpio_dout) | (~i_sel_gpio & i_per_dout);
  assign mux_oe = (i_sel_gpio & i_gpio_oe) | (~i_sel_gpio & i_per_oe);
  assign o_dout = mux_dout;
  // global release wins over any selection
  assign o_oe = i_three_state_all_request ? '0 : mux_oe;
endmodule // pgm_pin_cell
`default_nettype wire
